//--- rtl/eehs_top.sv
// Host command and busy handshake of the serial EEPROM controller.
//
// Notes on behaviour
// - Writing one to the busy bit 31 starts the operation in the op-code field at the held address.
// - The busy bit stays one for the whole operation and is cleared by hardware at its end.
// - After a read, busy returning to zero with the timeout flag clear means the data register holds the fetched byte.
// - A write with no EEPROM present keeps busy set until the timeout flag sets, then clears.
// - Busy is forced to one after any reset and cleared when the power-up loader finishes.
// - The op-code field 30:28 (000 read, 001 erase/write disable, 010 enable) resets to 000.
`timescale 1ns/1ns
`include "eehs_consts.svh"
module eehs_top #(
    parameter int TIMEOUT_CYCLES = `EEHS_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire eehs_pkg::eehs_acc_s acc,
    output logic [31:0] reg_rdata_q,
    output logic eeprom_op_busy_q,
    output logic eng_req_q,
    output eehs_pkg::eehs_req_s eng_cmd_q,
    input wire logic eng_done,
    input wire logic [`EEHS_DATA_W-1:0] eng_rdata,
    input wire logic loader_done
);
    eehs_pkg::eehs_state_e state_q;
    eehs_pkg::eehs_state_e state_d;
    logic [2:0] op_q;
    logic [`EEHS_EADDR_W-1:0] eaddr_q;
    logic [`EEHS_DATA_W-1:0] data_q;
    logic tmo_q;
    logic expire_q;

    // Address decode of the two registers.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : hit

    wire cmd_wr = acc.wr && hit(acc.addr, `EEHS_CMD_OFS);
    wire data_wr = acc.wr && hit(acc.addr, `EEHS_DATA_OFS);
    wire idle = (state_q == eehs_pkg::EEHS_IDLE);
    wire waiting = (state_q == eehs_pkg::EEHS_WAIT);
    // Writes while busy are dropped, so a careless host cannot corrupt a running operation.
    wire cmd_take = cmd_wr && idle;
    wire data_take = data_wr && idle;
    wire start = cmd_take && acc.wdata[`EEHS_BUSY_BIT];
    wire op_end = waiting && (eng_done || expire_q);
    wire tmo_clr = cmd_take && acc.wdata[`EEHS_TMO_BIT];
    wire tmo_set = waiting && !eng_done && expire_q;
    wire rd_fill = waiting && eng_done && (op_q == `EEHS_OP_READ);

    // Read view of the command register; bits 27:25 and 23:16 have no storage and read zero.
    // The view is built from live state, so a read during an operation shows busy as one.
    wire [31:0] cmd_view = {eeprom_op_busy_q, op_q, 3'h0, tmo_q, 8'h00, eaddr_q};
    wire [31:0] data_view = {{(32 - `EEHS_DATA_W){1'b0}}, data_q};
    wire [31:0] rd_mux = hit(acc.addr, `EEHS_CMD_OFS) ? cmd_view :
                         hit(acc.addr, `EEHS_DATA_OFS) ? data_view : 32'h0000_0000;

    // Next state of the handshake sequencer.
    always_comb begin
        state_d = state_q;
        case (state_q)
            eehs_pkg::EEHS_LOAD: begin
                if (loader_done) begin
                    state_d = eehs_pkg::EEHS_IDLE;
                end
            end
            eehs_pkg::EEHS_IDLE: begin
                if (start) begin
                    state_d = eehs_pkg::EEHS_WAIT;
                end
            end
            eehs_pkg::EEHS_WAIT: begin
                if (op_end) begin
                    state_d = eehs_pkg::EEHS_IDLE;
                end
            end
            default: begin
                state_d = eehs_pkg::EEHS_LOAD;
            end
        endcase
    end

    // Timeout watchdog for an engine that never answers.
    eehs_timer #(
        .CYCLES(TIMEOUT_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(waiting && !eng_done),
        .expire_q(expire_q)
    );

    // Sequencer state and busy flag; the soft reset behaves like a power-up.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= eehs_pkg::EEHS_LOAD;
            eeprom_op_busy_q <= 1'b1;
        end else if (soft_rst) begin
            state_q <= eehs_pkg::EEHS_LOAD;
            eeprom_op_busy_q <= 1'b1;
        end else begin
            state_q <= state_d;
            eeprom_op_busy_q <= (state_d != eehs_pkg::EEHS_IDLE);
        end
    end

    // Command fields, held steady while an operation runs.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_q <= `EEHS_OP_RESET;
            eaddr_q <= '0;
        end else if (soft_rst) begin
            op_q <= `EEHS_OP_RESET;
            eaddr_q <= '0;
        end else if (cmd_take) begin
            op_q <= acc.wdata[`EEHS_OP_MSB:`EEHS_OP_LSB];
            eaddr_q <= acc.wdata[`EEHS_EADDR_MSB:0];
        end
    end

    // Timeout flag: hardware setting wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tmo_q <= 1'b0;
        end else if (soft_rst) begin
            tmo_q <= 1'b0;
        end else begin
            tmo_q <= tmo_set | (tmo_q & ~tmo_clr);
        end
    end

    // Data register: host writes when idle, the engine fills it on a read.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_q <= '0;
        end else if (soft_rst) begin
            data_q <= '0;
        end else if (rd_fill) begin
            data_q <= eng_rdata;
        end else if (data_take) begin
            data_q <= acc.wdata[`EEHS_DATA_W-1:0];
        end
    end

    // Engine request pulse and registered read data.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eng_req_q <= 1'b0;
            eng_cmd_q <= '0;
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            eng_req_q <= start && !soft_rst;
            if (start) begin
                eng_cmd_q <= {acc.wdata[`EEHS_OP_MSB:`EEHS_OP_LSB],
                              acc.wdata[`EEHS_EADDR_MSB:0], data_q};
            end
            reg_rdata_q <= acc.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Checks sample on the rising edge and stand down during either reset, since both
    // reset paths force the sequencer back to the loader wait regardless of the host.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst || soft_rst);

    chk_start_on_one: assert property (
        cmd_wr && idle && acc.wdata[31] |=> eng_req_q && eeprom_op_busy_q
            && eng_cmd_q.op == $past(acc.wdata[30:28]))
        else $error("Command write with busy one did not start the engine.");

    chk_busy_while_run: assert property (
        waiting && !eng_done && !expire_q |=> eeprom_op_busy_q)
        else $error("Busy dropped while the operation was still running.");

    chk_busy_falls_done: assert property (
        waiting && eng_done |=> !eeprom_op_busy_q ##1 (!eeprom_op_busy_q || $past(start)))
        else $error("Busy did not clear after the engine finished.");

    chk_read_data_valid: assert property (
        rd_fill |=> data_q == $past(eng_rdata) && !eeprom_op_busy_q)
        else $error("Read result missing when busy cleared.");

    chk_timeout_clears: assert property (
        waiting && expire_q && !eng_done |=> tmo_q && !eeprom_op_busy_q)
        else $error("Timeout did not set its flag and clear busy together.");

    chk_busy_fall_cause: assert property (
        $fell(eeprom_op_busy_q) |-> $past(eng_done || expire_q || loader_done))
        else $error("Busy cleared without a finish, timeout or load end.");

    chk_load_release: assert property (
        state_q == eehs_pkg::EEHS_LOAD && loader_done |=> !eeprom_op_busy_q)
        else $error("Busy not cleared after the loader finished.");

    chk_op_steady: assert property (
        eeprom_op_busy_q && $past(eeprom_op_busy_q) && waiting |-> $stable(op_q)
            && $stable(eaddr_q))
        else $error("Command fields changed during an operation.");

    chk_zero_no_start: assert property (
        cmd_wr && !acc.wdata[`EEHS_BUSY_BIT] && !eng_done && !expire_q && !loader_done
            |=> !eng_req_q && $stable(state_q))
        else $error("Writing zero to busy changed the sequencer.");

    chk_req_one_pulse: assert property (
        eng_req_q |=> !eng_req_q)
        else $error("Engine start request lasted more than one cycle.");

    chk_cmd_matches: assert property (
        eng_req_q |-> eng_cmd_q.addr == eaddr_q && eng_cmd_q.op == op_q
            && eng_cmd_q.wdata == data_q)
        else $error("Engine request does not match the held command fields.");

    chk_timeout_rise: assert property (
        $rose(tmo_q) |-> $past(waiting && expire_q) && !eeprom_op_busy_q)
        else $error("Timeout flag set outside an expired operation.");

    chk_load_busy: assert property (
        state_q == eehs_pkg::EEHS_LOAD |-> eeprom_op_busy_q)
        else $error("Busy low while the loader has not finished.");
endmodule : eehs_top

//--- rtl/eehs_consts.svh
// Offsets, field positions, reset values and timing counts of the EEPROM command handshake.
`ifndef EEHS_CONSTS_SVH
`define EEHS_CONSTS_SVH
`define EEHS_ADDR_W 12
`define EEHS_CMD_OFS 12'h1B4
`define EEHS_DATA_OFS 12'h1C8
`define EEHS_BUSY_BIT 31
`define EEHS_OP_MSB 30
`define EEHS_OP_LSB 28
`define EEHS_TMO_BIT 24
`define EEHS_EADDR_MSB 15
`define EEHS_EADDR_W 16
`define EEHS_DATA_W 8
`define EEHS_OP_RESET 3'h0
`define EEHS_OP_READ 3'h0
`define EEHS_OP_ERASE_WRITE_DISABLE 3'h1
`define EEHS_OP_ERASE_WRITE_ENABLE 3'h2
`define EEHS_CLK_MHZ 250
`define EEHS_TIMEOUT_US 100
`define EEHS_TIMEOUT_CYC (`EEHS_TIMEOUT_US * `EEHS_CLK_MHZ)
`endif

//--- rtl/eehs_pkg.sv
// Types shared by the EEPROM command handshake files.
package eehs_pkg;
    typedef enum logic [1:0] {
        EEHS_LOAD,
        EEHS_IDLE,
        EEHS_WAIT
    } eehs_state_e;

    // Request handed to the serial EEPROM engine.
    typedef struct packed {
        logic [2:0] op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } eehs_req_s;

    // Host register access strobe with its address and data.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } eehs_acc_s;
endpackage : eehs_pkg

//--- rtl/eehs_timer.sv
// Timeout counter that fires once when an operation waits too long.
`timescale 1ns/1ns
module eehs_timer #(
    parameter int CYCLES = 25000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    output logic expire_q
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    wire at_last = (cnt_q == LAST);

    // The count restarts whenever run drops, so every wait gets a full window.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            expire_q <= 1'b0;
        end else begin
            cnt_q <= (run && !at_last) ? cnt_q + CW'(1) : '0;
            expire_q <= run && at_last;
        end
    end
endmodule : eehs_timer

//--- verif/eehs_eeprom_model.sv
// Behavioural serial EEPROM engine seen from the command handshake.
`timescale 1ns/1ns
module eehs_eeprom_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req,
    input wire eehs_pkg::eehs_req_s cmd,
    input wire logic absent,
    input wire logic [3:0] lat,
    output logic done,
    output logic [7:0] rdata
);
    logic [3:0] cnt_q;
    logic [7:0] byte_q;
    // Answers lat+1 cycles after a request; an absent part never answers.
    // Outside the answer cycle the byte toggles so a stale value is never trusted.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            byte_q <= 8'h00;
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= (cnt_q == 4'h1);
            rdata <= (cnt_q == 4'h1) ? byte_q : ~rdata;
            if (req && !absent) begin
                cnt_q <= lat;
                byte_q <= cmd.addr[7:0] ^ 8'h5A;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : eehs_eeprom_model

//--- verif/eehs_tb.sv
// Self-checking bench for the EEPROM command handshake.
`timescale 1ns/1ns
`include "eehs_consts.svh"
module tb;
    localparam int TMO = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0;
    logic loader_done = 1'b0;
    logic absent = 1'b0;
    logic [3:0] lat = 4'h2;
    eehs_pkg::eehs_acc_s acc = '0;
    eehs_pkg::eehs_req_s cmd;
    logic [31:0] rdata;
    logic busy, req, done;
    logic rd_seen = 1'b0;
    logic [7:0] erd, d;
    logic [15:0] a;
    logic [31:0] rq[$];
    logic [26:0] cq[$];
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    always #2 sys_clk = ~sys_clk;
    eehs_top #(.TIMEOUT_CYCLES(TMO)) dut (.sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst),
        .acc(acc), .reg_rdata_q(rdata), .eeprom_op_busy_q(busy), .eng_req_q(req),
        .eng_cmd_q(cmd), .eng_done(done), .eng_rdata(erd), .loader_done(loader_done));
    eehs_eeprom_model part (.sys_clk(sys_clk), .rst(rst), .req(req), .cmd(cmd),
        .absent(absent), .lat(lat), .done(done), .rdata(erd));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // A result with no note pending is itself a fault, so stray starts are caught.
    always @(posedge sys_clk) rd_seen <= acc.rd;
    always @(negedge sys_clk) begin
        if (rd_seen) chk("read", rq.size() ? rq.pop_front() : 32'hDEAD_BEEF, rdata);
        if (req === 1'b1) chk("start", cq.size() ? 32'(cq.pop_front()) : 32'hFFFF_FFFF, 32'(cmd));
    end
    task automatic wr(logic [11:0] ad, logic [31:0] v);
        @(negedge sys_clk);
        acc = '{1'b1, 1'b0, ad, v};
        @(negedge sys_clk);
        acc.wr = 1'b0;
    endtask : wr
    task automatic rd(logic [11:0] ad, logic [31:0] e);
        @(negedge sys_clk);
        acc = '{1'b0, 1'b1, ad, 32'h0};
        rq.push_back(e);
        @(negedge sys_clk);
        acc.rd = 1'b0;
    endtask : rd
    task automatic idle_wait(output int k);
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (busy !== 1'b0 && k < 200);
    endtask : idle_wait
    task automatic load();
        @(negedge sys_clk);
        loader_done = 1'b1;
        @(negedge sys_clk);
        loader_done = 1'b0;
    endtask : load
    task automatic tally_and_finish();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // The whole run is about a hundred cycles, so this limit only trips on a hang.
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h91AC));
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        rd(`EEHS_CMD_OFS, 32'h8000_0000);
        load();
        rd(`EEHS_CMD_OFS, 32'h0000_0000);
        $display("test reset done");
        for (int op = 0; op < 3; op++) begin
            a = 16'($urandom);
            d = 8'($urandom);
            lat = 4'($urandom_range(6, 2));
            wr(`EEHS_DATA_OFS, {24'h0, d});
            cq.push_back({3'(op), a, d});
            wr(`EEHS_CMD_OFS, {1'b1, 3'(op), 12'h0, a});
            rd(`EEHS_CMD_OFS, {1'b1, 3'(op), 12'h0, a});
            idle_wait(n);
            rd(`EEHS_CMD_OFS, {1'b0, 3'(op), 12'h0, a});
            if (op == 0) rd(`EEHS_DATA_OFS, {24'h0, a[7:0] ^ 8'h5A});
        end
        wr(`EEHS_CMD_OFS, 32'h2000_0055);
        rd(`EEHS_CMD_OFS, 32'h2000_0055);
        $display("test operations done");
        absent = 1'b1;
        cq.push_back({3'h1, 16'h0033, d});
        wr(`EEHS_CMD_OFS, 32'h9000_0033);
        idle_wait(n);
        chk("timeout span", 32'h1, 32'(n >= TMO - 1 && n <= TMO + 3));
        rd(`EEHS_CMD_OFS, 32'h1100_0033);
        wr(`EEHS_CMD_OFS, 32'h0100_0000);
        rd(`EEHS_CMD_OFS, 32'h0000_0000);
        $display("test timeout done");
        absent = 1'b0;
        @(negedge sys_clk);
        soft_rst = 1'b1;
        @(negedge sys_clk);
        soft_rst = 1'b0;
        rd(`EEHS_CMD_OFS, 32'h8000_0000);
        load();
        rd(`EEHS_CMD_OFS, 32'h0000_0000);
        rd(12'h1B8, 32'h0000_0000);
        repeat (3) @(negedge sys_clk);
        chk("pending notes", 32'h0, 32'(rq.size() + cq.size()));
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule : tb
